/* srl_repeater.sv */
// two-segment repeater: carrier/collision sensing, retimed forwarding, jam
// ----------------------------------------------------------------
// Overview of operation
// - carrier sense drops within 160 ns after line activity stops.
// - after the last valid bit of a frame no further bit is sent on.
// - each segment has its own carrier sense with station timing.
// - once carrier is seen on one segment its signal goes to the other while carrier lasts.
// - forwarded bits are decoded and re-encoded against the local bit timing.
// - steady-state forwarding delay stays within 800 ns.
// - each segment has its own collision detect with station timing.
// - a collision on either side while forwarding is made visible to all stations.
// - the collision indication reaches the other segment within 200 ns.
// - carrier sense rises within 200 ns of carrier onset.
// - collision detect rises within 200 ns of onset and drops within 160 ns of its end.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module srl_repeater
  import srl_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic seg_a_rx,
  input  wire logic seg_a_col,
  input  wire logic seg_b_rx,
  input  wire logic seg_b_col,
  output var  logic seg_a_tx,
  output var  logic seg_a_tx_en,
  output var  logic seg_b_tx,
  output var  logic seg_b_tx_en,
  output var  logic seg_a_carrier,
  output var  logic seg_b_carrier,
  output var  logic seg_a_collision,
  output var  logic seg_b_collision
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_BW = $clog2(BUF_DEPTH + 1);
  localparam logic [CNT_BW-1:0] BUF_FULL = CNT_BW'(BUF_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);

  // ----------------------------------------------------------------
  // per-segment sensing and decoding
  // ----------------------------------------------------------------
  wire [1:0] rx_pin;
  wire [1:0] col_pin;
  wire [1:0] cs_w;
  wire [1:0] cd_w;
  wire [1:0] bit_vld;
  wire [1:0] bit_val;
  wire [1:0] cs_nx;
  wire [1:0] cd_nx;

  assign rx_pin  = {seg_b_rx, seg_a_rx};
  assign col_pin = {seg_b_col, seg_a_col};

  for (genvar i = 0; i < 2; i++) begin : g_seg
    logic             rx_meta_ff;
    logic             rx_sync_ff;
    logic             rx_last_ff;
    logic             col_meta_ff;
    logic             col_sync_ff;
    logic             col_last_ff;
    logic [CNT_W-1:0] cs_cnt_ff;
    logic [CNT_W-1:0] cd_cnt_ff;
    logic [GAP_W-1:0] gap_ff;
    logic             cs_ff;
    logic             cd_ff;
    logic             vld_d1_ff;
    logic             vld_d2_ff;
    logic             val_d1_ff;
    logic             val_d2_ff;
    wire              rx_edge;
    wire              col_act;
    wire              accept;
    wire  [CNT_W-1:0] nxt_cs_cnt;
    wire  [CNT_W-1:0] nxt_cd_cnt;
    wire  [GAP_W-1:0] nxt_gap;

    assign rx_edge = rx_sync_ff ^ rx_last_ff;
    // collision presence may toggle, so either level or edge counts
    assign col_act = col_sync_ff | (col_sync_ff ^ col_last_ff);

    // hold counters retrigger on activity, bounded fall time
    assign nxt_cs_cnt = (rx_edge | col_act) ? CS_HOLD_LD :
                        (cs_cnt_ff != '0) ? cs_cnt_ff - 1'b1 : cs_cnt_ff;
    assign nxt_cd_cnt = col_act ? CD_HOLD_LD :
                        (cd_cnt_ff != '0) ? cd_cnt_ff - 1'b1 : cd_cnt_ff;

    // first edge of a burst, or an edge at least 4 cycles (three quarters of a bit plus one) after the last mid-bit
    assign accept  = rx_edge & (~cs_ff | (gap_ff >= GAP_MIN));
    assign nxt_gap = accept ? GAP_W'(1) : (gap_ff == GAP_MAX) ? gap_ff : gap_ff + 1'b1;

    // second half of a cell carries the true bit value
    // two-cycle delay lets the state machine leave idle before the first bit
    assign bit_vld[i] = vld_d2_ff;
    assign bit_val[i] = val_d2_ff;
    assign cs_nx[i]   = (nxt_cs_cnt != '0);
    assign cd_nx[i]   = (nxt_cd_cnt != '0);
    assign cs_w[i]    = cs_ff;
    assign cd_w[i]    = cd_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        rx_meta_ff  <= 1'b0;
        rx_sync_ff  <= 1'b0;
        rx_last_ff  <= 1'b0;
        col_meta_ff <= 1'b0;
        col_sync_ff <= 1'b0;
        col_last_ff <= 1'b0;
      end else begin
        rx_meta_ff  <= rx_pin[i];
        rx_sync_ff  <= rx_meta_ff;
        rx_last_ff  <= rx_sync_ff;
        col_meta_ff <= col_pin[i];
        col_sync_ff <= col_meta_ff;
        col_last_ff <= col_sync_ff;
      end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        cs_cnt_ff <= '0;
        cd_cnt_ff <= '0;
        gap_ff    <= GAP_MAX;
        cs_ff     <= 1'b0;
        cd_ff     <= 1'b0;
        vld_d1_ff <= 1'b0;
        vld_d2_ff <= 1'b0;
        val_d1_ff <= 1'b0;
        val_d2_ff <= 1'b0;
      end else begin
        cs_cnt_ff <= nxt_cs_cnt;
        cd_cnt_ff <= nxt_cd_cnt;
        gap_ff    <= nxt_gap;
        cs_ff     <= (nxt_cs_cnt != '0);
        cd_ff     <= (nxt_cd_cnt != '0);
        vld_d1_ff <= accept & ~cd_ff;
        vld_d2_ff <= vld_d1_ff;
        val_d1_ff <= rx_sync_ff;
        val_d2_ff <= val_d1_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // repeat state machine
  // ----------------------------------------------------------------
  srl_state_e state_ff;
  srl_state_e nxt_state;
  logic       armed_ff;
  logic [PH_W-1:0] ph_ff;
  logic       active_ff;
  logic       cur_bit_ff;

  wire        bit_stb;
  wire        fwd;
  wire        src;
  wire        any_cd;
  wire        buf_empty;
  wire        start_a;
  wire        start_b;
  wire        fwd_done;

  assign bit_stb = (ph_ff == PH_LAST);
  assign fwd     = (state_ff == ST_A2B) | (state_ff == ST_B2A);
  assign src     = (state_ff == ST_B2A);
  assign any_cd  = |cd_w;
  // the quiet requirement stops our own tail being echoed back
  assign start_a = armed_ff & cs_w[0];
  assign start_b = armed_ff & cs_w[1] & ~cs_w[0];
  // only decoded bits are sent, so the frame ends clean
  assign fwd_done = ~cs_w[src] & buf_empty & bit_stb;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_a) begin
          nxt_state = ST_A2B;
        end else if (start_b) begin
          nxt_state = ST_B2A;
        end
      end
      ST_A2B, ST_B2A: begin
        if (any_cd) begin
          nxt_state = ST_JAM;
        end else if (fwd_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_JAM: begin
        if (!any_cd && bit_stb) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      armed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      armed_ff <= (state_ff == ST_IDLE) & (armed_ff | ~(|cs_w));
    end
  end

  // ----------------------------------------------------------------
  // retiming buffer
  // ----------------------------------------------------------------
  logic [BUF_DEPTH-1:0] buf_mem_ff;
  logic [PTR_W-1:0]     wr_ptr_ff;
  logic [PTR_W-1:0]     rd_ptr_ff;
  logic [CNT_BW-1:0]    buf_cnt_ff;

  wire                  in_valid;
  wire                  in_ready;
  wire                  out_valid;
  wire                  out_ready;
  wire                  push;
  wire                  pop;

  // encoder drains at line rate, so the buffer only absorbs phase slip
  assign in_valid  = fwd & bit_vld[src];
  assign in_ready  = (buf_cnt_ff != BUF_FULL);
  assign out_valid = ~buf_empty;
  assign out_ready = fwd & bit_stb;
  assign buf_empty = (buf_cnt_ff == '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buf_mem_ff <= '0;
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      buf_cnt_ff <= '0;
    end else if (!fwd) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      buf_cnt_ff <= '0;
    end else begin
      if (push) begin
        buf_mem_ff[wr_ptr_ff] <= bit_val[src];
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
      buf_cnt_ff <= buf_cnt_ff + CNT_BW'(push) - CNT_BW'(pop);
    end
  end

  // ----------------------------------------------------------------
  // local bit clock and encoder
  // ----------------------------------------------------------------
  // odd cycles per bit: first half is one cycle longer than the second
  wire       jam;
  wire       nxt_active;
  wire       nxt_bit;
  wire       line;
  wire [1:0] tgt;

  assign jam        = (state_ff == ST_JAM);
  assign nxt_active = jam | pop;
  // jam is alternating ones and zeros, a legal encoded stream
  assign nxt_bit    = jam ? ~cur_bit_ff : buf_mem_ff[rd_ptr_ff];
  assign line       = active_ff & ((ph_ff < PH_HALF) ? ~cur_bit_ff : cur_bit_ff);
  // forward only away from the source; jam goes to every segment that is not colliding, source included
  assign tgt        = (state_ff == ST_A2B) ? 2'b10 :
                      (state_ff == ST_B2A) ? 2'b01 :
                      jam ? ~cd_w : 2'b00;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ph_ff      <= '0;
      active_ff  <= 1'b0;
      cur_bit_ff <= 1'b0;
    end else begin
      ph_ff <= bit_stb ? '0 : ph_ff + 1'b1;
      if (bit_stb) begin
        active_ff  <= nxt_active;
        cur_bit_ff <= nxt_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seg_a_tx        <= 1'b0;
      seg_a_tx_en     <= 1'b0;
      seg_b_tx        <= 1'b0;
      seg_b_tx_en     <= 1'b0;
      seg_a_carrier   <= 1'b0;
      seg_b_carrier   <= 1'b0;
      seg_a_collision <= 1'b0;
      seg_b_collision <= 1'b0;
    end else begin
      seg_a_tx        <= line & tgt[0];
      seg_a_tx_en     <= active_ff & tgt[0];
      seg_b_tx        <= line & tgt[1];
      seg_b_tx_en     <= active_ff & tgt[1];
      // next-count taps keep the fall within 160 ns of the pin
      seg_a_carrier   <= cs_nx[0];
      seg_b_carrier   <= cs_nx[1];
      seg_a_collision <= cd_nx[0];
      seg_b_collision <= cd_nx[1];
    end
  end

endmodule : srl_repeater

`default_nettype wire

/* srl_pkg.sv */
// constants and types shared by the segment repeater logic
`default_nettype none

package srl_pkg;

  // ----------------------------------------------------------------
  // clock and line timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int BIT_NS       = 100;
  localparam int CS_DROP_NS   = 160;
  localparam int CD_DROP_NS   = 160;
  localparam int FWD_DELAY_NS = 800;
  localparam int JAM_DELAY_NS = 200;
  localparam int SYNC_STAGES  = 2;

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam int BIT_CYC       = (BIT_NS * CLK_MHZ) / 1000;
  localparam int HALF_CYC      = (BIT_CYC + 1) / 2;
  // pin to flag costs the sync stages plus one counter load; 5 still bridges a bit cell
  localparam int CS_HOLD_CYC   = (CS_DROP_NS * CLK_MHZ) / 1000 - SYNC_STAGES - 1;
  localparam int CD_HOLD_CYC   = (CD_DROP_NS * CLK_MHZ) / 1000 - SYNC_STAGES - 1;
  localparam int MIDBIT_MIN    = (BIT_CYC * 3) / 4 + 1;

  localparam int CNT_W = 3;
  localparam int GAP_W = 4;
  localparam int PH_W  = 3;

  localparam logic [CNT_W-1:0] CS_HOLD_LD = CNT_W'(CS_HOLD_CYC);
  localparam logic [CNT_W-1:0] CD_HOLD_LD = CNT_W'(CD_HOLD_CYC);
  localparam logic [GAP_W-1:0] GAP_MIN    = GAP_W'(MIDBIT_MIN);
  localparam logic [GAP_W-1:0] GAP_MAX    = 4'hf;
  localparam logic [PH_W-1:0]  PH_LAST    = PH_W'(BIT_CYC - 1);
  localparam logic [PH_W-1:0]  PH_HALF    = PH_W'(HALF_CYC);

  // ----------------------------------------------------------------
  // repeater states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_A2B  = 2'b01,
    ST_B2A  = 2'b10,
    ST_JAM  = 2'b11
  } srl_state_e;

endpackage : srl_pkg

`default_nettype wire

/* srl_seg_xcvr.sv */
// segment transceiver model: manchester sender, collision source, bit receiver
`timescale 1ns/10ps
`default_nettype none
// ------
// transceiver model
// ------
module srl_seg_xcvr (
  input  wire logic mclk,
  input  wire logic tx,
  input  wire logic tx_en,
  output var  logic rx,
  output var  logic col
);
  logic [2:0]  ph_ff;
  logic [31:0] got_ff;
  int          cnt;
  initial begin
    rx     = 1'b0;
    col    = 1'b0;
    ph_ff  = 3'h0;
    got_ff = 32'h0;
    cnt    = 0;
  end
  // bit phase follows tx_en; second half holds the true bit
  always @(posedge mclk) begin
    ph_ff <= (tx_en && ph_ff != 3'h4) ? ph_ff + 3'h1 : 3'h0;
    if (tx_en && ph_ff == 3'h3) begin
      got_ff <= {got_ff[30:0], tx};
      cnt    <= cnt + 1;
    end
  end
  // idle line rests quiet: any toggle there would read as carrier
  task automatic send(input int n, input logic [31:0] d);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk) rx <= ~d[i];
      repeat (2) @(posedge mclk);
      @(posedge mclk) rx <= d[i];
      @(posedge mclk);
    end
  endtask : send
  task automatic clash(input int n);
    @(posedge mclk) col <= 1'b1;
    repeat (n) @(posedge mclk);
    col <= 1'b0;
  endtask : clash
endmodule : srl_seg_xcvr
`default_nettype wire

/* srl_repeater_sva.sv */
// port checks for the segment repeater logic
`timescale 1ns/10ps
`default_nettype none
module srl_repeater_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic seg_a_rx,
  input wire logic seg_a_col,
  input wire logic seg_b_rx,
  input wire logic seg_b_col,
  input wire logic seg_a_tx,
  input wire logic seg_a_tx_en,
  input wire logic seg_b_tx,
  input wire logic seg_b_tx_en,
  input wire logic seg_a_carrier,
  input wire logic seg_b_carrier,
  input wire logic seg_a_collision,
  input wire logic seg_b_collision
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ------
  // sensing and repeat
  // ------
  carrier_rise_a: assert property ($changed(seg_a_rx) |-> ##[1:10] seg_a_carrier)
    else $error("carrier a late");
  carrier_drop_a: assert property ((!seg_a_col && $stable(seg_a_rx)) [*8] |=> !seg_a_carrier)
    else $error("carrier a held");
  cs_b_drop_a: assert property ((!seg_b_col && $stable(seg_b_rx)) [*8] |=> !seg_b_carrier)
    else $error("carrier b held");
  coll_rise_a: assert property ($rose(seg_a_col) |-> ##[1:10] seg_a_collision)
    else $error("collision a late");
  cd_b_drop_a: assert property (!seg_b_col [*8] |=> !seg_b_collision)
    else $error("collision b held");
  jam_onto_a: assert property ($rose(seg_b_collision) && seg_a_carrier && !seg_a_collision
    |-> ##[1:10] seg_a_tx_en)
    else $error("no jam on a");
  jam_into_b_a: assert property ($rose(seg_a_collision) && seg_b_carrier && !seg_b_collision
    |-> ##[1:10] seg_b_tx_en)
    else $error("no jam on b");
  // a colliding segment b is left alone
  b_left_alone_a: assert property (seg_b_collision [*8] |-> !seg_b_tx_en)
    else $error("drive into collision");
  fwd_start_a: assert property ($rose(seg_a_carrier) && !seg_b_carrier |-> ##[1:40] seg_b_tx_en)
    else $error("forward late");
  cover property (seg_a_carrier && seg_b_tx_en);
  cover property (seg_b_carrier && seg_a_tx_en);
  cover property (seg_b_collision && seg_a_tx_en);
endmodule : srl_repeater_sva
bind srl_repeater srl_repeater_sva srl_repeater_sva_inst (.mclk, .reset_n, .seg_a_rx, .seg_a_col, .seg_b_rx,
  .seg_b_col, .seg_a_tx, .seg_a_tx_en, .seg_b_tx, .seg_b_tx_en, .seg_a_carrier, .seg_b_carrier,
  .seg_a_collision, .seg_b_collision);
`default_nettype wire

/* srl_repeater_tb.sv */
// self-checking bench for the segment repeater logic
`timescale 1ns/10ps
`default_nettype none
module srl_repeater_tb;
  logic mclk, reset_n, seg_a_rx, seg_a_col, seg_b_rx, seg_b_col;
  logic seg_a_tx, seg_a_tx_en, seg_b_tx, seg_b_tx_en;
  logic seg_a_carrier, seg_b_carrier, seg_a_collision, seg_b_collision;
  int   errors    = 0;
  int   tests_run = 0;
  srl_repeater srl_repeater_inst (.mclk, .reset_n, .seg_a_rx, .seg_a_col, .seg_b_rx, .seg_b_col,
    .seg_a_tx, .seg_a_tx_en, .seg_b_tx, .seg_b_tx_en, .seg_a_carrier, .seg_b_carrier,
    .seg_a_collision, .seg_b_collision);
  srl_seg_xcvr xa (.mclk, .tx(seg_a_tx), .tx_en(seg_a_tx_en), .rx(seg_a_rx), .col(seg_a_col));
  srl_seg_xcvr xb (.mclk, .tx(seg_b_tx), .tx_en(seg_b_tx_en), .rx(seg_b_rx), .col(seg_b_col));
  // ------
  // checking and closing
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // ------
  // scenarios
  // ------
  task automatic t_fwd(input bit a2b, input logic [15:0] d);
    int na;
    int nb;
    na = xa.cnt;
    nb = xb.cnt;
    if (a2b) xa.send(16, {16'h0, d}); else xb.send(16, {16'h0, d});
    repeat (30) @(posedge mclk);
    check({16'h0, a2b ? xb.got_ff[15:0] : xa.got_ff[15:0]}, {16'h0, d});
    check(32'(a2b ? xb.cnt - nb : xa.cnt - na), 32'h10);
    check(32'(a2b ? xa.cnt - na : xb.cnt - nb), 32'h0);
    check({30'h0, seg_a_carrier, seg_b_carrier}, 32'h0);
  endtask : t_fwd
  // collision mid-frame on the far segment; jam must reach the source
  task automatic t_clash(input bit a2b);
    int          n;
    logic [31:0] g;
    n = a2b ? xa.cnt : xb.cnt;
    fork
      if (a2b) xa.send(32, 32'hb5a6_9cf2); else xb.send(32, 32'hb5a6_9cf2);
      begin
        repeat (60) @(posedge mclk);
        if (a2b) xb.clash(40); else xa.clash(40);
      end
    join
    repeat (30) @(posedge mclk);
    g = a2b ? xa.got_ff : xb.got_ff;
    check(32'((a2b ? xa.cnt : xb.cnt) - n >= 2), 32'h1);
    check({31'h0, g[1] ^ g[0]}, 32'h1);
  endtask : t_clash
  // ------
  // run
  // ------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_fwd(1'b1, 16'hb5a6);
    t_fwd(1'b0, 16'h9cf2);
    t_clash(1'b1);
    t_clash(1'b0);
    t_fwd(1'b1, 16'hc3a2);
    stop_test();
  end
  // whole run is near 15 us; three times that means a hang
  initial begin
    #50000;
    errors++;
    stop_test();
  end
endmodule : srl_repeater_tb
`default_nettype wire
